//--- pnds_pkg.sv
package pnds_pkg;

   localparam int unsigned GROUPS = 4;
   localparam int unsigned NIB_W = 4;
   localparam int unsigned SEL_W = 2;
   localparam int unsigned OUT_W = 16;
   localparam int unsigned DEC_W = 8;

   // Register byte offsets, decoded from the low address bits only.
   localparam logic [7:0] OFF_ENA_HIGH = 8'h00;
   localparam logic [7:0] OFF_ENA_LOW = 8'h04;
   localparam logic [7:0] OFF_POD_HIGH = 8'h08;
   localparam logic [7:0] OFF_POD_LOW = 8'h0C;
   localparam logic [7:0] OFF_TRIG_SEL = 8'h10;
   localparam logic [7:0] OFF_NEXT_HIGH_A = 8'h14;
   localparam logic [7:0] OFF_NEXT_HIGH_B = 8'h18;
   localparam logic [7:0] OFF_NEXT_LOW_A = 8'h1C;
   localparam logic [7:0] OFF_NEXT_LOW_B = 8'h20;

   localparam logic [7:0] RST_ENA = 8'h00;
   localparam logic [15:0] RST_POD = 16'h0000;
   localparam logic [15:0] RST_NEXT = 16'h0000;
   localparam logic [7:0] RST_TRIG_SEL = 8'hFF;
   localparam logic [31:0] RST_RDATA = 32'h00000000;
   localparam logic [3:0] NIB_ONES = 4'hF;
   localparam logic [31:0] RDATA_ZERO = 32'h00000000;

   localparam logic HRESP_OKAY = 1'b0;
   localparam logic HREADY_RST = 1'b1;

   typedef struct packed {
      logic [7:0] ena_high;
      logic [7:0] ena_low;
      logic [15:0] pod;
      logic [15:0] next_pat;
      logic [7:0] trig_sel;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic hready;
      logic hresp;
   } pnds_state_t;

   localparam pnds_state_t RST_STATE = '{
      ena_high: RST_ENA,
      ena_low: RST_ENA,
      pod: RST_POD,
      next_pat: RST_NEXT,
      trig_sel: RST_TRIG_SEL,
      wr_pend: 1'b0,
      wr_addr: OFF_ENA_HIGH,
      rdata: RST_RDATA,
      hready: HREADY_RST,
      hresp: HRESP_OKAY
   };

endpackage : pnds_pkg

//--- pnds_nibble_xfer.sv
module pnds_nibble_xfer (
   input wire logic [3:0] pod_i,
   input wire logic [3:0] next_i,
   input wire logic [3:0] ena_i,
   input wire logic trig_i,
   input wire logic wr_i,
   input wire logic [3:0] wr_data_i,
   output logic [3:0] pod_o
);

   // Enabled bits follow the trigger, the others follow software writes.
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         if (ena_i[b]) begin
            pod_o[b] = trig_i ? next_i[b] : pod_i[b];
         end else begin
            pod_o[b] = wr_i ? wr_data_i[b] : pod_i[b];
         end
      end
   end

endmodule : pnds_nibble_xfer

//--- pnds_staging.sv
// Operation
// - Sixteen staging bits: high register for outputs 15..8, low for 7..0.
// - Group trigger copies high staging bits into high output bits.
// - Group trigger copies low staging bits into low output bits.
// - Staging address map depends on shared or separate group triggers.
// - Groups 2 and 3 sharing a trigger: all high bits at one address.
// - Groups 2 and 3 separate: bits 15..12 and 11..8 at two addresses.
// - Groups 0 and 1 sharing a trigger: all low bits at one address.
// - Groups 0 and 1 separate: bits 7..4 and 3..0 at two addresses.
// - Split views read the unused nibble as ones and ignore writes to it.
// - Only bits with transfer enable set copy; others keep their value.
// - Enabled output bits ignore software writes; disabled ones accept them.
// - Each of the four groups selects its own trigger.
module pnds_staging (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic [3:0] cmp_match_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [15:0] pulse_output_o
);

   pnds_pkg::pnds_state_t q;
   pnds_pkg::pnds_state_t next_q;
   logic [3:0] grp_trig;
   logic [3:0] pod_wr;
   logic [15:0] pod_wd;
   logic [15:0] pod_nx;
   logic [15:0] ena_all;
   logic [7:0] wd;
   logic joint_high;
   logic joint_low;
   logic rd_joint_high;
   logic rd_joint_low;
   logic addr_take;

   assign ena_all = {q.ena_high, q.ena_low};

   // Each group picks one of the four compare-match lines.
   always_comb begin
      for (int g = 0; g < pnds_pkg::GROUPS; g++) begin
         grp_trig[g] = cmp_match_i[q.trig_sel[g * pnds_pkg::SEL_W +: pnds_pkg::SEL_W]];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < pnds_pkg::GROUPS; gi++) begin : g_nib
         pnds_nibble_xfer u_xfer (
            .pod_i(q.pod[gi * pnds_pkg::NIB_W +: pnds_pkg::NIB_W]),
            .next_i(q.next_pat[gi * pnds_pkg::NIB_W +: pnds_pkg::NIB_W]),
            .ena_i(ena_all[gi * pnds_pkg::NIB_W +: pnds_pkg::NIB_W]),
            .trig_i(grp_trig[gi]),
            .wr_i(pod_wr[gi]),
            .wr_data_i(pod_wd[gi * pnds_pkg::NIB_W +: pnds_pkg::NIB_W]),
            .pod_o(pod_nx[gi * pnds_pkg::NIB_W +: pnds_pkg::NIB_W])
         );
      end
   endgenerate

   // Read multiplexer; the staging views follow the trigger sharing.
   function automatic logic [31:0] read_mux(input logic [7:0] a, input pnds_pkg::pnds_state_t s,
                                           input logic jh, input logic jl);
      logic [31:0] r;
      r = pnds_pkg::RDATA_ZERO;
      case (a)
         pnds_pkg::OFF_ENA_HIGH: r[7:0] = s.ena_high;
         pnds_pkg::OFF_ENA_LOW: r[7:0] = s.ena_low;
         pnds_pkg::OFF_POD_HIGH: r[7:0] = s.pod[15:8];
         pnds_pkg::OFF_POD_LOW: r[7:0] = s.pod[7:0];
         pnds_pkg::OFF_TRIG_SEL: r[7:0] = s.trig_sel;
         pnds_pkg::OFF_NEXT_HIGH_A: begin
            r[7:0] = jh ? s.next_pat[15:8] : {s.next_pat[15:12], pnds_pkg::NIB_ONES};
         end
         pnds_pkg::OFF_NEXT_HIGH_B: begin
            if (!jh) begin
               r[7:0] = {pnds_pkg::NIB_ONES, s.next_pat[11:8]};
            end
         end
         pnds_pkg::OFF_NEXT_LOW_A: begin
            r[7:0] = jl ? s.next_pat[7:0] : {s.next_pat[7:4], pnds_pkg::NIB_ONES};
         end
         pnds_pkg::OFF_NEXT_LOW_B: begin
            if (!jl) begin
               r[7:0] = {pnds_pkg::NIB_ONES, s.next_pat[3:0]};
            end
         end
         default: r = pnds_pkg::RDATA_ZERO;
      endcase
      return r;
   endfunction : read_mux

   always_comb begin
      next_q = q;
      wd = hwdata_i[7:0];
      pod_wr = 4'h0;
      pod_wd = 16'h0000;
      // Shared trigger when both groups of a pair select the same line.
      joint_high = (q.trig_sel[7:6] == q.trig_sel[5:4]);
      joint_low = (q.trig_sel[3:2] == q.trig_sel[1:0]);
      if (q.wr_pend) begin
         case (q.wr_addr)
            pnds_pkg::OFF_ENA_HIGH: next_q.ena_high = wd;
            pnds_pkg::OFF_ENA_LOW: next_q.ena_low = wd;
            pnds_pkg::OFF_POD_HIGH: begin
               pod_wr[3:2] = 2'h3;
               pod_wd[15:8] = wd;
            end
            pnds_pkg::OFF_POD_LOW: begin
               pod_wr[1:0] = 2'h3;
               pod_wd[7:0] = wd;
            end
            pnds_pkg::OFF_TRIG_SEL: next_q.trig_sel = wd;
            pnds_pkg::OFF_NEXT_HIGH_A: begin
               if (joint_high) begin
                  next_q.next_pat[15:8] = wd;
               end else begin
                  next_q.next_pat[15:12] = wd[7:4];
               end
            end
            pnds_pkg::OFF_NEXT_HIGH_B: begin
               if (!joint_high) begin
                  next_q.next_pat[11:8] = wd[3:0];
               end
            end
            pnds_pkg::OFF_NEXT_LOW_A: begin
               if (joint_low) begin
                  next_q.next_pat[7:0] = wd;
               end else begin
                  next_q.next_pat[7:4] = wd[7:4];
               end
            end
            pnds_pkg::OFF_NEXT_LOW_B: begin
               if (!joint_low) begin
                  next_q.next_pat[3:0] = wd[3:0];
               end
            end
            default: next_q.wr_pend = 1'b0;
         endcase
      end
      next_q.pod = pod_nx;
      // Address phase; reads see any write completing in the same cycle.
      addr_take = hsel_i & hready_i & htrans_i[1];
      rd_joint_high = (next_q.trig_sel[7:6] == next_q.trig_sel[5:4]);
      rd_joint_low = (next_q.trig_sel[3:2] == next_q.trig_sel[1:0]);
      next_q.wr_pend = addr_take & hwrite_i;
      next_q.wr_addr = haddr_i[pnds_pkg::DEC_W - 1:0];
      if (addr_take && !hwrite_i) begin
         next_q.rdata = read_mux(haddr_i[pnds_pkg::DEC_W - 1:0], next_q, rd_joint_high,
                                 rd_joint_low);
      end else begin
         next_q.rdata = pnds_pkg::RDATA_ZERO;
      end
      next_q.hready = pnds_pkg::HREADY_RST;
      next_q.hresp = pnds_pkg::HRESP_OKAY;
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= pnds_pkg::RST_STATE;
      end else if (ce_i) begin
         q <= next_q;
      end
   end

   assign hrdata_o = q.rdata;
   assign hreadyout_o = q.hready;
   assign hresp_o = q.hresp;
   assign pulse_output_o = q.pod;

endmodule : pnds_staging

//--- pnds_timer_model.sv
module pnds_timer_model (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic fire_i,
   input wire logic [1:0] chan_i,
   input wire logic [3:0] delay_i,
   output logic [3:0] cmp_match_o,
   output logic busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   logic [1:0] chan;
   // A fired channel waits its delay, then gives a one-cycle compare match.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_o <= 1'b0;
         cnt <= 4'h0;
         chan <= 2'h0;
         cmp_match_o <= 4'h0;
      end else begin
         cmp_match_o <= 4'h0;
         if (fire_i && !busy_o) begin
            busy_o <= 1'b1;
            cnt <= delay_i;
            chan <= chan_i;
         end else if (busy_o && cnt == 4'h0) begin
            busy_o <= 1'b0;
            cmp_match_o[chan] <= 1'b1;
         end else if (busy_o) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule : pnds_timer_model

//--- pnds_staging_chk.sv
module pnds_staging_chk (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [3:0] cmp_match_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [15:0] pulse_output_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire logic tk = hsel_i && hready_i && htrans_i[1] && ce_i;
   sequence rd_at(logic [7:0] a);
      tk && !hwrite_i && haddr_i[7:0] == a;
   endsequence
   sequence quiet;
      (ce_i && !(tk && hwrite_i)) ##1 (ce_i && cmp_match_i == 4'h0);
   endsequence
   chk_rdata_upper_zero: assert property (hrdata_o[31:8] == 24'h000000)
      else $error("read data above bit 7 not zero");
   chk_reset_out_zero: assert property ($rose(reset_n_i) |-> pulse_output_o == 16'h0000)
      else $error("output data not zero after reset");
   chk_idle_rdata_zero: assert property (ce_i && !(tk && !hwrite_i) |=> hrdata_o == 32'h0)
      else $error("read data not zero outside a read");
   chk_bus_ready_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus not ready or not okay");
   chk_unmapped_zero: assert property (tk && !hwrite_i && haddr_i[7:0] > 8'h20 |=>
      hrdata_o == 32'h0) else $error("unmapped read not zero");
   chk_high_b_view: assert property (rd_at(pnds_pkg::OFF_NEXT_HIGH_B) |=>
      hrdata_o[7:4] == 4'hF || hrdata_o[7:0] == 8'h00) else $error("high view nibble");
   chk_low_b_view: assert property (rd_at(pnds_pkg::OFF_NEXT_LOW_B) |=>
      hrdata_o[7:4] == 4'hF || hrdata_o[7:0] == 8'h00) else $error("low view nibble");
   chk_out_quiet: assert property (quiet |=> $stable(pulse_output_o))
      else $error("output data changed with no trigger or write");
   chk_freeze_out_hold: assert property (!ce_i |=> $stable(pulse_output_o))
      else $error("output data changed while clock enable low");
endmodule : pnds_staging_chk
bind pnds_staging pnds_staging_chk pnds_staging_chk_inst (.ref_clk_i, .reset_n_i, .ce_i,
   .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .cmp_match_i, .hrdata_o, .hreadyout_o,
   .hresp_o, .pulse_output_o);

//--- pnds_staging_tb_top.sv
module pnds_staging_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic fire_i = 1'b0, hreadyout_o, hresp_o, busy_o;
   logic [1:0] htrans_i = 2'h0, chan_i = 2'h0;
   logic [3:0] delay_i = 4'h0, cmp_match;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
   logic [15:0] pulse_output_o;
   int mismatches = 0, n_checks = 0;
   pnds_staging pnds_staging_inst (.ref_clk_i, .reset_n_i, .ce_i, .hsel_i, .haddr_i, .htrans_i,
      .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .cmp_match_i(cmp_match),
      .hrdata_o, .hreadyout_o, .hresp_o, .pulse_output_o);
   pnds_timer_model pnds_timer_model_inst (.ref_clk_i, .reset_n_i, .fire_i, .chan_i, .delay_i,
      .cmp_match_o(cmp_match), .busy_o);
   initial forever #25 ref_clk_i = ~ref_clk_i;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic until_hi(input logic use_busy, input logic lvl);
      for (int i = 0; i < 20; i++) begin
         @(posedge ref_clk_i);
         if ((use_busy ? busy_o : hreadyout_o) === lvl) return;
      end
      mismatches++;
      finish_test();
   endtask : until_hi
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      @(posedge ref_clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      hwrite_i <= w;
      haddr_i <= {24'h000000, a};
      until_hi(1'b0, 1'b1);
      htrans_i <= 2'b00;
      hwdata_i <= {24'h000000, d};
      until_hi(1'b0, 1'b1);
      if (!w) chk(hrdata_o, {24'h000000, e});
   endtask : xfer
   task automatic trig(input logic [1:0] c, input logic [3:0] d, input logic [15:0] e);
      @(posedge ref_clk_i);
      fire_i <= 1'b1;
      chan_i <= c;
      delay_i <= d;
      @(posedge ref_clk_i);
      fire_i <= 1'b0;
      @(posedge ref_clk_i);
      until_hi(1'b1, 1'b0);
      @(negedge ref_clk_i);
      chk({16'h0000, pulse_output_o}, {16'h0000, e});
   endtask : trig
   initial begin
      repeat (10) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      for (int i = 0; i < 10; i++) xfer(1'b0, 8'(i * 4), 8'h00, (i == 4) ? 8'hFF : 8'h00);
      xfer(1'b1, pnds_pkg::OFF_NEXT_HIGH_A, 8'hA5, 8'h00);
      xfer(1'b0, pnds_pkg::OFF_NEXT_HIGH_A, 8'h00, 8'hA5);
      xfer(1'b0, pnds_pkg::OFF_NEXT_HIGH_B, 8'h00, 8'h00);
      xfer(1'b1, pnds_pkg::OFF_NEXT_LOW_A, 8'h3C, 8'h00);
      xfer(1'b0, pnds_pkg::OFF_NEXT_LOW_A, 8'h00, 8'h3C);
      xfer(1'b1, pnds_pkg::OFF_ENA_HIGH, 8'hF0, 8'h00);
      xfer(1'b1, pnds_pkg::OFF_ENA_LOW, 8'h0F, 8'h00);
      trig(2'h3, 4'h0, 16'hA00C);
      xfer(1'b1, pnds_pkg::OFF_POD_HIGH, 8'hFF, 8'h00);
      xfer(1'b1, pnds_pkg::OFF_POD_LOW, 8'hFF, 8'h00);
      xfer(1'b0, pnds_pkg::OFF_POD_HIGH, 8'h00, 8'hAF);
      xfer(1'b0, pnds_pkg::OFF_POD_LOW, 8'h00, 8'hFC);
      xfer(1'b1, pnds_pkg::OFF_TRIG_SEL, 8'hE4, 8'h00);
      xfer(1'b1, pnds_pkg::OFF_NEXT_HIGH_A, 8'h5A, 8'h00);
      xfer(1'b1, pnds_pkg::OFF_NEXT_HIGH_B, 8'hEC, 8'h00);
      xfer(1'b1, pnds_pkg::OFF_NEXT_LOW_B, 8'h09, 8'h00);
      xfer(1'b1, pnds_pkg::OFF_NEXT_LOW_A, 8'h7A, 8'h00);
      xfer(1'b0, pnds_pkg::OFF_NEXT_HIGH_A, 8'h00, 8'h5F);
      xfer(1'b0, pnds_pkg::OFF_NEXT_HIGH_B, 8'h00, 8'hFC);
      xfer(1'b0, pnds_pkg::OFF_NEXT_LOW_A, 8'h00, 8'h7F);
      xfer(1'b0, pnds_pkg::OFF_NEXT_LOW_B, 8'h00, 8'hF9);
      xfer(1'b1, pnds_pkg::OFF_ENA_HIGH, 8'hFF, 8'h00);
      xfer(1'b1, pnds_pkg::OFF_ENA_LOW, 8'hFF, 8'h00);
      trig(2'h2, 4'h0, 16'hACFC);
      trig(2'h0, 4'h5, 16'hACF9);
      trig(2'h3, 4'h1, 16'h5CF9);
      trig(2'h1, 4'h9, 16'h5C79);
      xfer(1'b1, pnds_pkg::OFF_NEXT_HIGH_B, 8'h03, 8'h00);
      @(posedge ref_clk_i);
      ce_i <= 1'b0;
      trig(2'h2, 4'h0, 16'h5C79);
      @(posedge ref_clk_i);
      ce_i <= 1'b1;
      trig(2'h2, 4'h0, 16'h5379);
      @(posedge ref_clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      xfer(1'b0, pnds_pkg::OFF_POD_HIGH, 8'h00, 8'h00);
      xfer(1'b0, pnds_pkg::OFF_NEXT_HIGH_A, 8'h00, 8'h00);
      xfer(1'b0, pnds_pkg::OFF_TRIG_SEL, 8'h00, 8'hFF);
      finish_test();
   end
endmodule : pnds_staging_tb_top
